// ==== core/uppi_defs.svh ====
/*
  Shared constants of the transceiver pin interface: timing, divider and
  start-up figures. Assumes inclusion by bare name from core/.
*/
`ifndef UPPI_DEFS_SVH
`define UPPI_DEFS_SVH

`define UPPI_CLK_HZ 10000000
`define UPPI_ULPI_CLK_HZ 60000000
`define UPPI_REF_CLK_HZ 13000000
`define UPPI_DATA_W 8
`define UPPI_DATA_MSB 7
`define UPPI_DATA_LSB 0
`define UPPI_IDLE_BYTE 8'h00
// Half period of the reference clock in core cycles, never below one
`define UPPI_REF_HALF_CYC (((`UPPI_CLK_HZ / (2 * `UPPI_REF_CLK_HZ)) > 0) ? \
  (`UPPI_CLK_HZ / (2 * `UPPI_REF_CLK_HZ)) : 1)
`define UPPI_REF_LOCK_EDGES 8
`define UPPI_REF_LOSS_CYC 16
`define UPPI_SRP_PULSE_NS 1000
`define UPPI_SRP_PULSE_CYC ((`UPPI_SRP_PULSE_NS * (`UPPI_CLK_HZ / 1000000)) / 1000)
`define UPPI_CNT_W 8

`endif

// ==== core/uppi_pkg.sv ====
/*
  Types of the transceiver pin interface: state encodings of both ends.
  Assumes uppi_defs.svh is compiled alongside.
*/
package uppi_pkg;
  typedef enum logic [2:0] {
    UPPI_P_IDLE,
    UPPI_P_TURN_OUT,
    UPPI_P_SEND,
    UPPI_P_TURN_IN,
    UPPI_P_RECV
  } uppi_phy_state_type;

  typedef enum logic [1:0] {
    UPPI_L_IDLE,
    UPPI_L_SEND,
    UPPI_L_STOP
  } uppi_link_state_type;
endpackage

// ==== core/uppi_if.sv ====
/*
  Pin bundle between the transceiver end and the link end. Resolves the
  shared data bus and the tri-statable pins from the output enables;
  an undriven wire reads as zero, except the cable supply, which reads vbus_cable.
*/
`timescale 1ns/1ps
interface uppi_if;
  logic [7:0] data_phy;
  logic data_phy_oe;
  logic [7:0] data_link;
  logic data_link_oe;
  logic [7:0] data;
  logic dir_o;
  logic dir_oe;
  logic dir;
  logic nxt_o;
  logic nxt_oe;
  logic nxt;
  logic stp;
  logic clk_o;
  logic clk_oe;
  logic phy_clock_output;
  logic ext_o;
  logic ext_oe;
  logic ext_supply_enable;
  logic vbus_o;
  logic vbus_oe;
  logic vbus_cable;
  logic vbus;
  logic suspend_reset_n;
  logic ref_clock_in;
  logic bus_clash;

  assign data = data_phy_oe ? data_phy : (data_link_oe ? data_link : 8'h00);
  assign bus_clash = data_phy_oe & data_link_oe;
  assign dir = dir_oe & dir_o;
  assign nxt = nxt_oe & nxt_o;
  assign phy_clock_output = clk_oe & clk_o;
  assign ext_supply_enable = ext_oe & ext_o;
  assign vbus = vbus_oe ? vbus_o : vbus_cable;

  modport phy (
    output data_phy, data_phy_oe, dir_o, dir_oe, nxt_o, nxt_oe,
    output clk_o, clk_oe, ext_o, ext_oe, vbus_o, vbus_oe,
    input data, stp, suspend_reset_n, ref_clock_in, vbus
  );
  modport link (
    output data_link, data_link_oe, stp, suspend_reset_n, ref_clock_in,
    input data, dir, nxt, phy_clock_output, ext_supply_enable
  );
endinterface

// ==== core/uppi_ref_monitor.sv ====
/*
  Reference clock watcher for the transceiver end. The reference input is
  taken as synchronous to the core clock; lock follows a run of rising
  edges and is dropped when edges stop.
*/
`timescale 1ns/1ps
`include "uppi_defs.svh"
module uppi_ref_monitor
  import uppi_pkg::*;
#(
  parameter int LOCK_EDGES = `UPPI_REF_LOCK_EDGES,
  parameter int LOSS_CYC = `UPPI_REF_LOSS_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ref_clock_in,
  output logic ref_locked
);
  typedef struct packed {
    logic ref_q;
    logic [`UPPI_CNT_W-1:0] edges;
    logic [`UPPI_CNT_W-1:0] quiet;
    logic locked;
  } uppi_refmon_type;

  uppi_refmon_type s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ref_q = ref_clock_in;
    if (ref_clock_in && !s_r.ref_q) begin
      s_nxt.quiet = '0;
      if (s_r.edges != LOCK_EDGES[`UPPI_CNT_W-1:0]) begin
        s_nxt.edges = s_r.edges + 1'b1;
      end
    end else if (s_r.quiet == LOSS_CYC[`UPPI_CNT_W-1:0]) begin
      // A stalled reference means no derived clocks, so lock is lost
      s_nxt.edges = '0;
    end else begin
      s_nxt.quiet = s_r.quiet + 1'b1;
    end
    s_nxt.locked = (s_nxt.edges == LOCK_EDGES[`UPPI_CNT_W-1:0]);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ref_locked = s_r.locked;
endmodule

// ==== core/uppi_phy_end.sv ====
/*
  Transceiver end of the pin interface: bus ownership, turnaround,
  throttling, stop handling, suspend tri-state, supply enable and cable
  supply sense/pulse. Assumes the link end keeps its own side of the bus
  and that all pins are synchronous to clock.
*/
// Functional notes
// - ULPI clock out; signals change on rising edge (clock out toggles every core cycle, so signals change at both its edges)
// - Drive direction high when sending to link
// - Idle: direction low, bus released, watched
// - Next strobe marks link byte accepted
// - Link shows next byte cycle after acceptance
// - Link stops stream with one-cycle stop
// - Stop means previous-cycle byte was last
// - Eight-bit bus, bit 7 most significant
// - Supply enable active high, low after reset
// - Suspend input low: all pins tri-stated
// - Suspend input high: normal transceiver operation
// - Reference clock supplied by system
// - Cable supply pin: sensing and session pulsing
`timescale 1ns/1ps
`include "uppi_defs.svh"
module uppi_phy_end
  import uppi_pkg::*;
#(
  parameter int DATA_W = `UPPI_DATA_W,
  parameter int SRP_PULSE_CYC = `UPPI_SRP_PULSE_CYC,
  parameter int LOCK_EDGES = `UPPI_REF_LOCK_EDGES
) (
  input wire logic clock,
  input wire logic sys_rst,
  uppi_if.phy pins,
  input wire logic tx_valid,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  input wire logic rx_accept,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  input wire logic supply_enable_req,
  input wire logic srp_pulse_req,
  output logic vbus_present,
  output logic active
);
  typedef struct packed {
    uppi_phy_state_type st;
    logic dir;
    logic dir_oe;
    logic nxt;
    logic nxt_oe;
    logic [DATA_W-1:0] dout;
    logic dout_oe;
    logic [DATA_W-1:0] pend;
    logic pend_v;
    logic [DATA_W-1:0] rx_data;
    logic rx_valid;
    logic rx_last;
    logic tx_ready;
    logic clk_out;
    logic clk_oe;
    logic ext_en;
    logic ext_oe;
    logic vbus_present;
    logic vbus_drive;
    logic [`UPPI_CNT_W-1:0] pulse_cnt;
    logic active;
  } uppi_phy_regs_type;

  uppi_phy_regs_type s_r, s_nxt;
  logic ref_locked;
  logic run;
  logic tx_take;

  uppi_ref_monitor #(
    .LOCK_EDGES(LOCK_EDGES),
    .LOSS_CYC(`UPPI_REF_LOSS_CYC)
  ) u_ref (
    .clock(clock),
    .sys_rst(sys_rst),
    .ref_clock_in(pins.ref_clock_in),
    .ref_locked(ref_locked)
  );

  always_comb begin
    s_nxt = s_r;
    run = pins.suspend_reset_n && ref_locked;
    tx_take = tx_valid && s_r.tx_ready;
    s_nxt.rx_valid = 1'b0;
    s_nxt.rx_last = 1'b0;
    s_nxt.nxt = 1'b0;
    s_nxt.clk_out = ~s_r.clk_out;
    s_nxt.vbus_present = pins.vbus;
    s_nxt.ext_en = supply_enable_req;

    case (s_r.st)
      UPPI_P_IDLE: begin
        // Bus released while direction is low; link commands are watched
        s_nxt.dir = 1'b0;
        s_nxt.dout_oe = 1'b0;
        s_nxt.tx_ready = 1'b0;
        if (pins.data != `UPPI_IDLE_BYTE) begin
          // Link command has priority; the first byte is held until taken
          s_nxt.st = UPPI_P_RECV;
          s_nxt.nxt = rx_accept && !pins.stp;
        end else if (tx_valid) begin
          s_nxt.st = UPPI_P_TURN_OUT;
          s_nxt.dir = 1'b1;
        end
      end
      UPPI_P_TURN_OUT: begin
        // Direction is high but nobody drives for this one cycle
        s_nxt.dout_oe = 1'b0;
        s_nxt.st = UPPI_P_SEND;
        s_nxt.tx_ready = 1'b1;
      end
      UPPI_P_SEND: begin
        s_nxt.dout_oe = 1'b1;
        if (tx_take) begin
          s_nxt.dout = tx_data;
          s_nxt.nxt = 1'b1;
          if (tx_last) begin
            s_nxt.tx_ready = 1'b0;
            s_nxt.st = UPPI_P_TURN_IN;
          end
        end else begin
          // Underrun shows as an idle status byte with the strobe low
          s_nxt.dout = `UPPI_IDLE_BYTE;
        end
      end
      UPPI_P_TURN_IN: begin
        s_nxt.dir = 1'b0;
        s_nxt.dout_oe = 1'b0;
        s_nxt.dout = `UPPI_IDLE_BYTE;
        s_nxt.st = UPPI_P_IDLE;
      end
      UPPI_P_RECV: begin
        // A byte is taken only in a strobe cycle that is not a stop cycle
        if (s_r.nxt && !pins.stp) begin
          if (s_r.pend_v) begin
            s_nxt.rx_data = s_r.pend;
            s_nxt.rx_valid = 1'b1;
          end
          s_nxt.pend = pins.data;
          s_nxt.pend_v = 1'b1;
        end
        if (pins.stp) begin
          // The byte held back is the final one of the stream
          s_nxt.rx_data = s_r.pend;
          s_nxt.rx_valid = s_r.pend_v;
          s_nxt.rx_last = s_r.pend_v;
          s_nxt.pend_v = 1'b0;
          s_nxt.st = UPPI_P_IDLE;
        end else begin
          s_nxt.nxt = rx_accept;
        end
      end
      default: begin
        s_nxt.st = UPPI_P_IDLE;
      end
    endcase

    // Session request pulse drives the cable supply for a fixed time
    if (s_r.pulse_cnt != '0) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt - 1'b1;
    end else if (srp_pulse_req && !pins.vbus) begin
      s_nxt.pulse_cnt = SRP_PULSE_CYC[`UPPI_CNT_W-1:0];
    end
    s_nxt.vbus_drive = (s_nxt.pulse_cnt != '0);

    s_nxt.active = run;
    s_nxt.dir_oe = run;
    s_nxt.nxt_oe = run;
    s_nxt.clk_oe = run;
    s_nxt.ext_oe = run;

    if (!run) begin
      // Suspended: every pin floats and the bus machine restarts idle
      s_nxt.st = UPPI_P_IDLE;
      s_nxt.dir = 1'b0;
      s_nxt.nxt = 1'b0;
      s_nxt.dout_oe = 1'b0;
      s_nxt.tx_ready = 1'b0;
      s_nxt.pend_v = 1'b0;
      s_nxt.vbus_drive = 1'b0;
      s_nxt.pulse_cnt = '0;
      s_nxt.clk_out = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.st <= UPPI_P_IDLE;
      s_r.dout <= `UPPI_IDLE_BYTE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins.data_phy = s_r.dout;
  assign pins.data_phy_oe = s_r.dout_oe;
  assign pins.dir_o = s_r.dir;
  assign pins.dir_oe = s_r.dir_oe;
  assign pins.nxt_o = s_r.nxt;
  assign pins.nxt_oe = s_r.nxt_oe;
  assign pins.clk_o = s_r.clk_out;
  assign pins.clk_oe = s_r.clk_oe;
  assign pins.ext_o = s_r.ext_en;
  assign pins.ext_oe = s_r.ext_oe;
  assign pins.vbus_o = 1'b1;
  assign pins.vbus_oe = s_r.vbus_drive;
  assign tx_ready = s_r.tx_ready;
  assign rx_data = s_r.rx_data;
  assign rx_valid = s_r.rx_valid;
  assign rx_last = s_r.rx_last;
  assign vbus_present = s_r.vbus_present;
  assign active = s_r.active;
endmodule

// ==== core/uppi_link_end.sv ====
/*
  Link end of the pin interface: reference clock generation, suspend
  control, transmit with stop strobe and receive of transceiver bytes.
  Assumes the transceiver end keeps its side of the bus.
*/
`timescale 1ns/1ps
`include "uppi_defs.svh"
module uppi_link_end
  import uppi_pkg::*;
#(
  parameter int DATA_W = `UPPI_DATA_W,
  parameter int REF_HALF_CYC = `UPPI_REF_HALF_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  uppi_if.link pins,
  input wire logic run_req,
  input wire logic tx_valid,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_valid,
  output logic rx_cmd,
  output logic rx_end,
  output logic supply_on
);
  typedef struct packed {
    uppi_link_state_type st;
    logic [DATA_W-1:0] cur;
    logic cur_v;
    logic cur_last;
    logic [DATA_W-1:0] pre;
    logic pre_v;
    logic pre_last;
    logic tx_ready;
    logic dout_oe;
    logic stp;
    logic dir_q;
    logic [DATA_W-1:0] rx_data;
    logic rx_valid;
    logic rx_cmd;
    logic rx_end;
    logic run;
    logic ref_clk;
    logic [`UPPI_CNT_W-1:0] ref_cnt;
    logic supply_on;
  } uppi_link_regs_type;

  uppi_link_regs_type s_r, s_nxt;
  logic own_bus;
  logic taken;

  always_comb begin
    s_nxt = s_r;
    s_nxt.dir_q = pins.dir;
    s_nxt.stp = 1'b0;
    s_nxt.rx_valid = 1'b0;
    s_nxt.rx_end = 1'b0;
    s_nxt.run = run_req;
    s_nxt.supply_on = pins.ext_supply_enable;
    // Bus is ours only after direction has been low for a full cycle
    own_bus = !pins.dir && !s_r.dir_q;
    taken = s_r.dout_oe && s_r.cur_v && pins.nxt;

    if (s_r.ref_cnt == REF_HALF_CYC[`UPPI_CNT_W-1:0] - 1'b1) begin
      s_nxt.ref_cnt = '0;
      s_nxt.ref_clk = ~s_r.ref_clk;
    end else begin
      s_nxt.ref_cnt = s_r.ref_cnt + 1'b1;
    end

    if (tx_valid && s_r.tx_ready) begin
      s_nxt.pre = tx_data;
      s_nxt.pre_v = 1'b1;
      s_nxt.pre_last = tx_last;
    end

    case (s_r.st)
      UPPI_L_IDLE: begin
        s_nxt.dout_oe = 1'b0;
        if (s_nxt.pre_v && own_bus) begin
          s_nxt.cur = s_nxt.pre;
          s_nxt.cur_v = 1'b1;
          s_nxt.cur_last = s_nxt.pre_last;
          s_nxt.pre_v = 1'b0;
          s_nxt.dout_oe = 1'b1;
          s_nxt.st = UPPI_L_SEND;
        end
      end
      UPPI_L_SEND: begin
        if (pins.dir) begin
          // Transceiver took the bus: the byte on the bus is dropped
          s_nxt.dout_oe = 1'b0;
          s_nxt.cur_v = 1'b0;
          s_nxt.st = UPPI_L_IDLE;
        end else if (taken) begin
          if (s_r.cur_last) begin
            s_nxt.stp = 1'b1;
            s_nxt.cur = `UPPI_IDLE_BYTE;
            s_nxt.cur_v = 1'b0;
            s_nxt.st = UPPI_L_STOP;
          end else begin
            // Next byte goes out right after acceptance, even one taken this edge
            s_nxt.cur = s_nxt.pre;
            s_nxt.cur_v = s_nxt.pre_v;
            s_nxt.cur_last = s_nxt.pre_last;
            s_nxt.pre_v = 1'b0;
          end
        end else if (!s_r.cur_v && s_nxt.pre_v) begin
          s_nxt.cur = s_nxt.pre;
          s_nxt.cur_v = 1'b1;
          s_nxt.cur_last = s_nxt.pre_last;
          s_nxt.pre_v = 1'b0;
        end
      end
      UPPI_L_STOP: begin
        s_nxt.dout_oe = 1'b0;
        s_nxt.st = UPPI_L_IDLE;
      end
      default: begin
        s_nxt.st = UPPI_L_IDLE;
      end
    endcase

    if (pins.dir && s_r.dir_q) begin
      s_nxt.rx_data = pins.data;
      s_nxt.rx_valid = 1'b1;
      s_nxt.rx_cmd = !pins.nxt;
    end
    s_nxt.rx_end = !pins.dir && s_r.dir_q;
    s_nxt.tx_ready = !s_nxt.pre_v && s_r.run;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.st <= UPPI_L_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins.data_link = s_r.cur;
  assign pins.data_link_oe = s_r.dout_oe;
  assign pins.stp = s_r.stp;
  assign pins.suspend_reset_n = s_r.run;
  assign pins.ref_clock_in = s_r.ref_clk;
  assign tx_ready = s_r.tx_ready;
  assign rx_data = s_r.rx_data;
  assign rx_valid = s_r.rx_valid;
  assign rx_cmd = s_r.rx_cmd;
  assign rx_end = s_r.rx_end;
  assign supply_on = s_r.supply_on;
endmodule

// ==== sim/uppi_properties.sv ====
/*
  Concurrent checks on the pins joining the transceiver end and the link end.
  Assumes the bench wires the interface signals and the core clock here.
*/
`timescale 1ns/1ps
module uppi_properties (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] data,
  input wire logic data_phy_oe,
  input wire logic data_link_oe,
  input wire logic bus_clash,
  input wire logic dir,
  input wire logic dir_oe,
  input wire logic nxt,
  input wire logic nxt_oe,
  input wire logic stp,
  input wire logic clk_oe,
  input wire logic phy_clock_output,
  input wire logic ext_oe,
  input wire logic ext_supply_enable,
  input wire logic vbus_oe,
  input wire logic suspend_reset_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  no_bus_clash_a: assert property (!bus_clash)
    else $error("both ends drive data");
  turn_on_rise_a: assert property ($rose(dir) |-> !data_phy_oe && !data_link_oe)
    else $error("bus driven in turnaround after rise");
  turn_on_fall_a: assert property ($fell(dir) |-> !data_phy_oe && !data_link_oe)
    else $error("bus driven in turnaround after fall");
  idle_released_a: assert property (!dir |-> !data_phy_oe)
    else $error("transceiver drives bus with direction low");
  link_yields_a: assert property (dir |-> !data_link_oe)
    else $error("link drives bus while transceiver owns it");
  accept_needs_byte_a: assert property ($rose(nxt) && !dir && !stp |->
    data_link_oe && data != 8'h00)
    else $error("accept strobe without a link byte");
  stop_one_cycle_a: assert property (stp |=> !stp)
    else $error("stop strobe longer than one cycle");
  stop_releases_a: assert property (stp && data_link_oe |=> !data_link_oe)
    else $error("link still drives after stop");
  suspend_floats_a: assert property (!suspend_reset_n |=>
    !(data_phy_oe | dir_oe | nxt_oe | clk_oe | ext_oe | vbus_oe))
    else $error("pin driven while suspended");
  supply_off_reset_a: assert property ($fell(sys_rst) |-> !ext_supply_enable)
    else $error("supply enable high after reset");
  clock_toggles_a: assert property (clk_oe && $past(clk_oe) |->
    phy_clock_output != $past(phy_clock_output))
    else $error("bus clock output stopped");

  cover property ($rose(dir));
  cover property ($fell(dir));
  cover property (stp && data_link_oe);
endmodule

// ==== sim/tb_top.sv ====
/*
  Bench joining both ends over one interface, with a queue model of each
  stream. Assumes the core files and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb_top import uppi_pkg::*;;
  localparam int SRP_CYC = 10;
  logic clock;
  logic sys_rst;
  integer seed = 32'h927f;
  int num_errors = 0;
  int num_checks = 0;
  logic p_tx_valid, p_tx_last, p_tx_ready, p_rx_accept, p_rx_valid, p_rx_last;
  logic p_sup_req, p_srp_req, p_vbus_present, p_active;
  logic l_run_req, l_tx_valid, l_tx_last, l_tx_ready, l_rx_valid, l_rx_cmd;
  logic l_rx_end, l_supply_on;
  logic [7:0] p_tx_data, p_rx_data, l_tx_data, l_rx_data;
  logic [8:0] r_l2p[$];
  logic [7:0] w_l2p[$], w_p2l[$], r_p2l[$];
  logic [31:0] stall_pat;
  logic [4:0] rot = 5'h00;
  int n_end = 0;
  int n_p2l = 0;
  int cnt;

  uppi_if uppi_if_inst();
  uppi_phy_end #(.SRP_PULSE_CYC(SRP_CYC)) uppi_phy_end_inst (.clock(clock),
    .sys_rst(sys_rst), .pins(uppi_if_inst.phy), .tx_valid(p_tx_valid),
    .tx_data(p_tx_data), .tx_last(p_tx_last), .tx_ready(p_tx_ready),
    .rx_accept(p_rx_accept), .rx_data(p_rx_data), .rx_valid(p_rx_valid),
    .rx_last(p_rx_last), .supply_enable_req(p_sup_req), .srp_pulse_req(p_srp_req),
    .vbus_present(p_vbus_present), .active(p_active));
  uppi_link_end uppi_link_end_inst (.clock(clock), .sys_rst(sys_rst),
    .pins(uppi_if_inst.link), .run_req(l_run_req), .tx_valid(l_tx_valid),
    .tx_data(l_tx_data), .tx_last(l_tx_last), .tx_ready(l_tx_ready),
    .rx_data(l_rx_data), .rx_valid(l_rx_valid), .rx_cmd(l_rx_cmd),
    .rx_end(l_rx_end), .supply_on(l_supply_on));
  uppi_properties uppi_properties_inst (.clock(clock), .sys_rst(sys_rst),
    .data(uppi_if_inst.data), .data_phy_oe(uppi_if_inst.data_phy_oe),
    .data_link_oe(uppi_if_inst.data_link_oe), .bus_clash(uppi_if_inst.bus_clash),
    .dir(uppi_if_inst.dir), .dir_oe(uppi_if_inst.dir_oe), .nxt(uppi_if_inst.nxt),
    .nxt_oe(uppi_if_inst.nxt_oe), .stp(uppi_if_inst.stp), .clk_oe(uppi_if_inst.clk_oe),
    .phy_clock_output(uppi_if_inst.phy_clock_output), .ext_oe(uppi_if_inst.ext_oe),
    .ext_supply_enable(uppi_if_inst.ext_supply_enable), .vbus_oe(uppi_if_inst.vbus_oe),
    .suspend_reset_n(uppi_if_inst.suspend_reset_n));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic step();
    @(posedge clock);
    #10;
  endtask

  // Stall pattern rotates so the transceiver throttles mid-stream
  always @(posedge clock) begin
    #10 p_rx_accept = stall_pat[rot];
    rot = rot + 5'h01;
  end

  always @(posedge clock) begin
    if (p_rx_valid === 1'b1)
      check(r_l2p.size() > 0 && {p_rx_last, p_rx_data} === r_l2p.pop_front(), "rx at phy");
    if (l_rx_valid === 1'b1 && l_rx_cmd === 1'b0)
      check(r_p2l.size() > 0 && l_rx_data === r_p2l.pop_front(), "rx at link");
    if (l_rx_end === 1'b1)
      n_end++;
    if (!sys_rst && uppi_if_inst.dir === 1'b0 && uppi_if_inst.nxt === 1'b1
        && uppi_if_inst.stp === 1'b0 && uppi_if_inst.data_link_oe === 1'b1)
      check(w_l2p.size() > 0 && uppi_if_inst.data === w_l2p.pop_front(), "wire l2p");
    if (!sys_rst && uppi_if_inst.dir === 1'b1 && uppi_if_inst.nxt === 1'b1)
      check(w_p2l.size() > 0 && uppi_if_inst.data === w_p2l.pop_front(), "wire p2l");
  end

  task automatic send_frame(input bit p2l, input int n);
    logic [7:0] b;
    int w;
    stall_pat = $random(seed) | 32'h0000_0001;
    for (int i = 0; i < n; i++) begin
      b = $random(seed);
      if (b === 8'h00) b = 8'h01;
      if (p2l) begin
        w_p2l.push_back(b);
        r_p2l.push_back(b);
        {p_tx_valid, p_tx_data, p_tx_last} = {1'b1, b, i == n - 1};
      end else begin
        w_l2p.push_back(b);
        r_l2p.push_back({i == n - 1, b});
        {l_tx_valid, l_tx_data, l_tx_last} = {1'b1, b, i == n - 1};
      end
      w = 0;
      do begin
        @(posedge clock);
        w++;
      end while ((p2l ? p_tx_ready : l_tx_ready) !== 1'b1 && w < 200);
      check(w < 200, "byte not taken");
      #10;
    end
    p_tx_valid = 1'b0;
    l_tx_valid = 1'b0;
    if (p2l) n_p2l++;
  endtask

  task automatic idle_wait();
    int s;
    s = 0;
    for (int w = 0; w < 200 && s < 4; w++) begin
      @(posedge clock);
      s = (uppi_if_inst.dir === 1'b0 && uppi_if_inst.data_link_oe === 1'b0) ? s + 1 : 0;
    end
    #10;
    check(s == 4, "bus not idle");
  endtask

  task automatic wake();
    l_run_req = 1'b1;
    for (int w = 0; w < 100 && p_active !== 1'b1; w++) step();
    check(p_active === 1'b1, "not active");
  endtask

  task automatic frames(input int k);
    for (int i = 0; i < k; i++) begin
      send_frame($random(seed) & 1, 1 + i % 5);
      idle_wait();
    end
  endtask

  initial begin
    {sys_rst, stall_pat} = {1'b1, 32'hffff_ffff};
    {p_tx_valid, p_tx_last, p_tx_data, p_sup_req, p_srp_req} = 12'h000;
    {l_run_req, l_tx_valid, l_tx_last, l_tx_data} = 11'h000;
    uppi_if_inst.vbus_cable = 1'b0;
    repeat (8) @(posedge clock);
    #10 sys_rst = 1'b0;
    check(uppi_if_inst.ext_supply_enable === 1'b0, "supply after reset");
    wake();
    frames(12);
    p_sup_req = 1'b1;
    repeat (4) step();
    check(uppi_if_inst.ext_supply_enable === 1'b1 && l_supply_on === 1'b1, "supply");
    l_run_req = 1'b0;
    for (int w = 0; w < 20 && p_active !== 1'b0; w++) step();
    step();
    check({uppi_if_inst.dir_oe, uppi_if_inst.nxt_oe, uppi_if_inst.data_phy_oe,
      uppi_if_inst.clk_oe, uppi_if_inst.ext_oe, uppi_if_inst.vbus_oe} === 6'h00,
      "pins in suspend");
    wake();
    frames(6);
    uppi_if_inst.vbus_cable = 1'b1;
    repeat (4) step();
    check(p_vbus_present === 1'b1, "cable sense high");
    uppi_if_inst.vbus_cable = 1'b0;
    repeat (4) step();
    check(p_vbus_present === 1'b0, "cable sense low");
    p_srp_req = 1'b1;
    step();
    p_srp_req = 1'b0;
    cnt = 0;
    repeat (40) begin
      @(posedge clock);
      if (uppi_if_inst.vbus_oe === 1'b1) cnt++;
    end
    check(cnt == SRP_CYC, "session pulse length");
    check(r_l2p.size() == 0 && r_p2l.size() == 0 && n_end == n_p2l, "streams");
    end_of_test();
  end

  initial begin
    #(20000 * 100);
    num_errors++;
    $display("MISMATCH at %0t: watchdog", $time);
    end_of_test();
  end
endmodule
